// [design/tbd_cfg.svh]
// Timebase divider configuration constants
// Assumes inclusion by bare name from design files
`ifndef TBD_CFG_SVH
`define TBD_CFG_SVH

`define TBD_OFF_DIV_HIGH     12'h000
`define TBD_OFF_DIV_LOW      12'h004
`define TBD_OFF_SHD_HIGH     12'h008
`define TBD_OFF_SHD_LOW      12'h00C
`define TBD_OFF_CONFIG       12'h010
`define TBD_OFF_SHD_CMD      12'h014
`define TBD_OFF_STATUS       12'h018

`define TBD_LOCK_BIT         7
`define TBD_HIGH_DIV_MSB     2
`define TBD_CFG_CLKSEL_BIT   0
`define TBD_CFG_LATCH_BIT    1
`define TBD_CFG_FUTURE_BIT   2
`define TBD_CMD_PROG_BIT     0
`define TBD_CMD_ERASE_BIT    1
`define TBD_CMD_HIGH_BIT     2

`define TBD_SHD_ERASED       8'hFF
`define TBD_CONFIG_RESET     8'h00
`define TBD_TICK_NS          35000
`define TBD_CLK_NS           20
`define TBD_OSC_SYNC_STAGES  2

`endif

// [design/tbd_counter.sv]
// Divider counter producing one-cycle timebase ticks
// Assumes oscillator clock already synchronised as a level
`timescale 1ns/1ns
`default_nettype none
`include "tbd_cfg.svh"
module tbd_counter
    import tbd_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    input  wire logic osc_lvl_i,
    tbd_tick_if.cnt   tk
);
    logic     osc_prev_q, osc_prev_d;
    divisor_t cnt_q, cnt_d;
    logic     tick_q, tick_d;
    logic     ref_edge;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_comb
    begin
        osc_prev_d = osc_lvl_i;
        ref_edge   = tk.use_osc ? (osc_lvl_i & ~osc_prev_q) : 1'b1;
        cnt_d      = cnt_q;
        tick_d     = 1'b0;
        if (tk.divisor == 11'h000)
        begin
            cnt_d = 11'h000;
        end
        else if (ref_edge)
        begin
            if (cnt_q >= tk.divisor - 11'h001)
            begin
                cnt_d  = 11'h000;
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 11'h001;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            osc_prev_q <= 1'b0;
            cnt_q      <= 11'h000;
            tick_q     <= 1'b0;
        end
        else
        begin
            osc_prev_q <= osc_prev_d;
            cnt_q      <= cnt_d;
            tick_q     <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule
`default_nettype wire

// [design/tbd_pkg.sv]
// Types shared by the timebase divider design files
// Assumes no surroundings
package tbd_pkg;
    typedef logic [10:0] divisor_t;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ACC  = 2'b01
    } apb_state_t;
endpackage

// [design/tbd_tick_if.sv]
// Interface between register file and divider counter
// Assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface tbd_tick_if;
    import tbd_pkg::*;
    divisor_t divisor;
    logic     use_osc;
    logic     tick;
    modport ctrl (output divisor, output use_osc, input tick);
    modport cnt  (input divisor, input use_osc, output tick);
endinterface
`default_nettype wire

// [design/tbd_top.sv]
// EEPROM timebase divider: APB registers, shadow copies and counter
// Assumes APB master on core_clk_i; oscillator clock arrives asynchronous
//
// Behaviour
// - Deliver a constant 35 us tick when a proper divisor is loaded.
// - Reference clock is oscillator or bus clock, chosen by config bit.
// - Reset copies both shadow registers into the divider registers.
// - Eleven-bit divisor split high/low, lock-disable bit in high register.
// - Stored value divides reference; period is divisor reference periods.
// - Lock-disable bit: 1 security off, 0 security on.
// - Security on ignores writes to both divider registers and lock bit.
// - Security on blocks erase and program of both shadow registers.
// - Divisor always readable; writable only with future config bit set, latch clear, lock bit set.
// - Proposed addresses ignore writes on current revision.
// - New shadow contents reach divider registers only at system reset.
// - Shadow lock bit zero makes lock permanent across resets.
// - Unlocked shadow registers erase and program like EEPROM bytes.
`timescale 1ns/1ns
`default_nettype none
`include "tbd_cfg.svh"
module tbd_top
    import tbd_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        osc_clk_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             timebase_tick_o,
    output logic             divider_locked_o
);
    tbd_tick_if tk ();

    logic [7:0] div_high_q, div_high_d;
    logic [7:0] div_low_q, div_low_d;
    logic [7:0] shd_high_q = `TBD_SHD_ERASED;
    logic [7:0] shd_high_d;
    logic [7:0] shd_low_q  = `TBD_SHD_ERASED;
    logic [7:0] shd_low_d;
    logic [7:0] config_q, config_d;
    logic       prog_fail_q, prog_fail_d;
    logic [`TBD_OSC_SYNC_STAGES-1:0] osc_sync_q;
    apb_state_t st_q, st_d;
    logic [31:0] prdata_d;
    logic        pslverr_d;
    logic        pready_d;
    logic        tick_out_q;
    logic        locked_out_q;
    logic        load_q;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic wr_allowed(input logic [7:0] hi, input logic [7:0] cfg);
        wr_allowed = hi[`TBD_LOCK_BIT] & ~cfg[`TBD_CFG_LATCH_BIT];
    endfunction

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        if (a == `TBD_OFF_DIV_HIGH)
        begin
            mapped = 1'b1;
        end
        else if (a == `TBD_OFF_DIV_LOW)
        begin
            mapped = 1'b1;
        end
        else if (a == `TBD_OFF_SHD_HIGH)
        begin
            mapped = 1'b1;
        end
        else if (a == `TBD_OFF_SHD_LOW)
        begin
            mapped = 1'b1;
        end
        else if (a == `TBD_OFF_CONFIG)
        begin
            mapped = 1'b1;
        end
        else if (a == `TBD_OFF_SHD_CMD)
        begin
            mapped = 1'b1;
        end
        else if (a == `TBD_OFF_STATUS)
        begin
            mapped = 1'b1;
        end
        else
        begin
            mapped = 1'b0;
        end
    endfunction

    // ----------------------------------------
    // Oscillator synchroniser
    // ----------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            osc_sync_q <= '0;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[0], osc_clk_i};
        end
    end

    // ----------------------------------------
    // Register file and APB slave
    // ----------------------------------------
    always_comb
    begin
        div_high_d  = div_high_q;
        div_low_d   = div_low_q;
        shd_high_d  = shd_high_q;
        shd_low_d   = shd_low_q;
        config_d    = config_q;
        prog_fail_d = prog_fail_q;
        st_d        = st_q;
        prdata_d    = 32'h00000000;
        pslverr_d   = 1'b0;
        pready_d    = 1'b0;
        if (load_q)
        begin
            div_high_d = {shd_high_q[`TBD_LOCK_BIT], 4'h0, shd_high_q[2:0]};
            div_low_d  = shd_low_q;
        end
        // Writes land only at the edge where pready is seen high
        if (pready && psel && penable && pwrite)
        begin
            if (paddr == `TBD_OFF_DIV_HIGH)
            begin
                if (config_q[`TBD_CFG_FUTURE_BIT] && wr_allowed(div_high_q, config_q))
                begin
                    div_high_d = {pwdata[7], 4'h0, pwdata[2:0]};
                end
            end
            else if (paddr == `TBD_OFF_DIV_LOW)
            begin
                if (config_q[`TBD_CFG_FUTURE_BIT] && wr_allowed(div_high_q, config_q))
                begin
                    div_low_d = pwdata[7:0];
                end
            end
            else if (paddr == `TBD_OFF_SHD_CMD)
            begin
                if (!div_high_q[`TBD_LOCK_BIT])
                begin
                    prog_fail_d = 1'b1;
                end
                else if (pwdata[`TBD_CMD_ERASE_BIT])
                begin
                    prog_fail_d = 1'b0;
                    if (pwdata[`TBD_CMD_HIGH_BIT])
                    begin
                        shd_high_d = `TBD_SHD_ERASED;
                    end
                    else
                    begin
                        shd_low_d = `TBD_SHD_ERASED;
                    end
                end
                else if (pwdata[`TBD_CMD_PROG_BIT])
                begin
                    prog_fail_d = 1'b0;
                    if (pwdata[`TBD_CMD_HIGH_BIT])
                    begin
                        shd_high_d = shd_high_q & pwdata[15:8];
                    end
                    else
                    begin
                        shd_low_d = shd_low_q & pwdata[15:8];
                    end
                end
            end
            else if (paddr == `TBD_OFF_CONFIG)
            begin
                config_d = {5'h00, pwdata[2:0]};
            end
        end
        case (st_q)
            ST_IDLE:
            begin
                if (psel && !penable)
                begin
                    st_d = ST_ACC;
                end
            end
            ST_ACC:
            begin
                pready_d  = 1'b1;
                st_d      = ST_IDLE;
                pslverr_d = ~mapped(paddr);
                if (!pwrite)
                begin
                    if (paddr == `TBD_OFF_DIV_HIGH)
                    begin
                        prdata_d = zext8(div_high_q);
                    end
                    else if (paddr == `TBD_OFF_DIV_LOW)
                    begin
                        prdata_d = zext8(div_low_q);
                    end
                    else if (paddr == `TBD_OFF_SHD_HIGH)
                    begin
                        prdata_d = zext8(shd_high_q);
                    end
                    else if (paddr == `TBD_OFF_SHD_LOW)
                    begin
                        prdata_d = zext8(shd_low_q);
                    end
                    else if (paddr == `TBD_OFF_CONFIG)
                    begin
                        prdata_d = zext8(config_q);
                    end
                    else if (paddr == `TBD_OFF_STATUS)
                    begin
                        prdata_d = {30'h0, prog_fail_q, ~div_high_q[`TBD_LOCK_BIT]};
                    end
                    else if (paddr == `TBD_OFF_SHD_CMD)
                    begin
                        prdata_d = 32'h00000000;
                    end
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            div_high_q   <= 8'h00;
            div_low_q    <= 8'h00;
            config_q     <= `TBD_CONFIG_RESET;
            prog_fail_q  <= 1'b0;
            st_q         <= ST_IDLE;
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            load_q       <= 1'b1;
            tick_out_q   <= 1'b0;
            locked_out_q <= 1'b0;
        end
        else
        begin
            div_high_q   <= div_high_d;
            div_low_q    <= div_low_d;
            config_q     <= config_d;
            prog_fail_q  <= prog_fail_d;
            st_q         <= st_d;
            prdata       <= prdata_d;
            pready       <= pready_d;
            pslverr      <= pslverr_d;
            load_q       <= 1'b0;
            tick_out_q   <= tk.tick;
            locked_out_q <= ~div_high_d[`TBD_LOCK_BIT];
        end
    end

    // ----------------------------------------
    // Non-volatile shadows survive reset
    // ----------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        shd_high_q <= shd_high_d;
        shd_low_q  <= shd_low_d;
    end

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    assign tk.divisor = {div_high_q[`TBD_HIGH_DIV_MSB:0], div_low_q};
    assign tk.use_osc = config_q[`TBD_CFG_CLKSEL_BIT];

    tbd_counter u_counter
    (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .osc_lvl_i  (osc_sync_q[1]),
        .tk         (tk)
    );

    assign timebase_tick_o  = tick_out_q;
    assign divider_locked_o = locked_out_q;
endmodule
`default_nettype wire

// [verif/tbd_timer_model.sv]
// Program/erase timer model measuring the tick interval
// Assumes tick_i is a one-cycle pulse on core_clk_i
`timescale 1ns/1ns
`default_nettype none
module tbd_timer_model
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        tick_i,
    output var  logic [15:0] period_o,
    output var  int          ticks_o
);
    // ---
    // Interval between ticks
    // ---
    logic [15:0] cnt_q;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q    <= 16'h0000;
            period_o <= 16'h0000;
            ticks_o  <= 0;
        end
        else if (tick_i)
        begin
            cnt_q    <= 16'h0001;
            period_o <= cnt_q;
            ticks_o  <= ticks_o + 1;
        end
        else
            cnt_q <= cnt_q + 16'h0001;
    end
endmodule
`default_nettype wire

// [verif/tbd_top_asserts.sv]
// Checker for the divider register port and lock pin
// Assumes it is bound onto tbd_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module tbd_top_asserts
(
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        divider_locked_o
);
    // ---
    // Bus and lock properties
    // ---
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    a_ready_timing: assert property (s_setup |-> ##2 pready)
        else $error("pready missing two cycles after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_phase: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h018))
        else $error("pslverr wrong for address");
    a_status_lock: assert property (s_read(12'h018) |-> prdata[0] == divider_locked_o)
        else $error("status lock bit differs from pin");
    a_high_lock: assert property (s_read(12'h000) |-> prdata[7] == !divider_locked_o)
        else $error("lock disable bit differs from pin");
    a_high_pad: assert property (s_read(12'h000) |-> prdata[6:3] == 4'h0)
        else $error("unused high bits not zero");
    a_lock_kept: assert property (divider_locked_o |=> divider_locked_o)
        else $error("lock released without reset");
endmodule
bind tbd_top tbd_top_asserts u_chk (.core_clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .divider_locked_o);
`default_nettype wire

// [verif/tbd_top_test.sv]
// Self-checking bench for the timebase divider
// Assumes design, checker and timer model compiled before it
`timescale 1ns/1ns
`default_nettype none
module tbd_top_test;
    // ---
    // Stimulus and checks
    // ---
    localparam int DIV_BUS = $rtoi(50.0e6 * 35.0e-6 + 0.5);
    localparam int DIV_OSC = $rtoi(4.0e6 * 35.0e-6 + 0.5);
    logic        clk     = 1'b0;
    logic        osc     = 1'b0;
    logic        rst_b   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tick;
    logic        locked;
    logic [15:0] period;
    int          ticks;
    logic [31:0] rd;
    logic        er;
    int          fails       = 0;
    int          comparisons = 0;

    always #10 clk = ~clk;
    always #125 osc = ~osc;

    tbd_top u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .osc_clk_i(osc), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timebase_tick_o(tick),
        .divider_locked_o(locked));
    tbd_timer_model u_tmr (.core_clk_i(clk), .rst_b_i(rst_b), .tick_i(tick),
        .period_o(period), .ticks_o(ticks));

    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic give_up();
        fails++;
        $display("ERROR wait expected end seen timeout");
        conclude();
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            give_up();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check($sformatf("register %h", a), exp, rd);
    endtask

    task automatic set_div(input int dv);
        xfer(1'b1, 12'h000, 32'(dv >> 8) | 32'h0000_0080);
        xfer(1'b1, 12'h004, 32'(dv & 255));
    endtask

    task automatic ticks_chk(input int exp, input int tol);
        int start;
        int n;
        start = ticks;
        n = 0;
        while (ticks < start + 2 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000)
            give_up();
        comparisons++;
        if ((period >= 16'(exp - tol) && period <= 16'(exp + tol)) !== 1'b1)
        begin
            fails++;
            $display("ERROR tick period expected %0d seen %0d", exp, period);
        end
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask

    initial
    begin
        do_reset();
        rdchk(12'h000, 32'h0000_0087);
        rdchk(12'h004, 32'h0000_00FF);
        xfer(1'b1, 12'h004, 32'h0000_0011);
        rdchk(12'h004, 32'h0000_00FF);
        xfer(1'b1, 12'h010, 32'h0000_0006);
        xfer(1'b1, 12'h004, 32'h0000_0011);
        rdchk(12'h004, 32'h0000_00FF);
        xfer(1'b1, 12'h010, 32'h0000_0004);
        set_div(DIV_BUS);
        rdchk(12'h004, 32'(DIV_BUS & 255));
        ticks_chk(DIV_BUS, 0);
        set_div(DIV_OSC);
        xfer(1'b1, 12'h010, 32'h0000_0005);
        ticks_chk(DIV_OSC * 25 / 2, 1);
        xfer(1'b1, 12'h01C, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0, er});
        xfer(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped read error", 32'h0000_0001, {31'h0, er});
        xfer(1'b1, 12'h014, 32'h0000_D601);
        rdchk(12'h00C, 32'h0000_00D6);
        rdchk(12'h004, 32'(DIV_OSC & 255));
        xfer(1'b1, 12'h014, 32'h0000_0006);
        rdchk(12'h008, 32'h0000_00FF);
        xfer(1'b1, 12'h014, 32'h0000_0605);
        rdchk(12'h008, 32'h0000_0006);
        rdchk(12'h000, 32'h0000_0080);
        do_reset();
        rdchk(12'h000, 32'h0000_0006);
        rdchk(12'h018, 32'h0000_0001);
        check("lock pin", 32'h0000_0001, {31'h0, locked});
        xfer(1'b1, 12'h010, 32'h0000_0004);
        xfer(1'b1, 12'h004, 32'h0000_0011);
        xfer(1'b1, 12'h000, 32'h0000_0087);
        rdchk(12'h004, 32'h0000_00D6);
        rdchk(12'h000, 32'h0000_0006);
        xfer(1'b1, 12'h014, 32'h0000_0006);
        rdchk(12'h018, 32'h0000_0003);
        rdchk(12'h008, 32'h0000_0006);
        ticks_chk(DIV_BUS, 0);
        do_reset();
        rdchk(12'h000, 32'h0000_0006);
        conclude();
    end
endmodule
`default_nettype wire
